// ### iox_pkg.sv
// constants, field layouts and carrier types of the io crossbar
// assumes one 50 MHz clock domain and the internal register port of the host serial slave
package iox_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int IOX_NPORT = 6;
    localparam int IOX_NFUNC = 11;
    localparam int IOX_AW = 7;
    localparam int IOX_DW = 8;

    // ****************************************************************
    // register offsets and reset values
    // ****************************************************************
    localparam logic [IOX_AW-1:0] IOX_OFS_CMD_CFG = 7'h05;
    localparam logic [IOX_AW-1:0] IOX_OFS_SENS_CFG = 7'h07;
    localparam logic [IOX_AW-1:0] IOX_OFS_XBAR = 7'h0c;
    localparam logic [IOX_AW-1:0] IOX_OFS_MAP_STAT = 7'h0d;
    localparam logic [IOX_DW-1:0] IOX_RST_CMD_CFG = 8'h00;
    localparam logic [IOX_DW-1:0] IOX_RST_SENS_CFG = 8'h00;
    localparam logic [IOX_DW-1:0] IOX_RST_XBAR = 8'h00;
    localparam logic [IOX_DW-1:0] IOX_RD_NONE = 8'h00;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int IOX_XB_PINSET_LSB = 0;
    localparam int IOX_XB_PINSET_MSB = 2;
    localparam int IOX_XB_CLK_BIT = 3;
    localparam int IOX_XB_IRQ_BIT = 4;
    localparam int IOX_XB_MAO_BIT = 5;
    localparam int IOX_XB_SLI_BIT = 6;
    localparam int IOX_XB_SLO_BIT = 7;
    localparam int IOX_CMD_CPL_BIT = 5;
    localparam int IOX_SENS_EN_BIT = 6;

    // ****************************************************************
    // sensor pin-set codes
    // ****************************************************************
    localparam logic [2:0] IOX_PS_NONE = 3'h0;
    localparam logic [2:0] IOX_PS_CK_DO_DI = 3'h1;
    localparam logic [2:0] IOX_PS_CK_DO = 3'h2;
    localparam logic [2:0] IOX_PS_CK_DI = 3'h3;
    localparam logic [2:0] IOX_PS_RSVD = 3'h4;
    localparam logic [2:0] IOX_PS_CK_DO_DI_CS = 3'h5;
    localparam logic [2:0] IOX_PS_CK_DO_CS = 3'h6;
    localparam logic [2:0] IOX_PS_CK_DI_CS = 3'h7;

    // ****************************************************************
    // functions in descending priority, bit 0 of a port mask is io1
    // ****************************************************************
    localparam int FN_SCLK = 0;
    localparam int FN_DOUT = 1;
    localparam int FN_DIN = 2;
    localparam int FN_SEL = 3;
    localparam int FN_CLK = 4;
    localparam int FN_IRQ = 5;
    localparam int FN_MAO = 6;
    localparam int FN_SLI = 7;
    localparam int FN_CPL = 8;
    localparam int FN_CHAIN_DATA_OUT = 9;
    localparam int FN_CHAIN_DATA_RETURN = 10;
    localparam logic [IOX_NPORT-1:0] FN_ALLOWED [IOX_NFUNC] = '{
        6'h01, 6'h02, 6'h06, 6'h0c, 6'h3f, 6'h3f, 6'h3e, 6'h3c, 6'h38, 6'h30, 6'h20};
    localparam logic [IOX_NFUNC-1:0] FN_IS_OUT = 11'h36b;
    localparam logic [IOX_NPORT-1:0] IOX_NO_PORT = 6'h00;
    localparam logic [IOX_NPORT-1:0] IOX_PORT1 = 6'h01;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        IOX_CPL_CLOSED = 2'b01,
        IOX_CPL_OPEN = 2'b10
    } iox_cpl_e;

    typedef struct packed {
        logic sclk;
        logic mosi;
        logic sel;
    } iox_sens_s;

    typedef struct packed {
        logic clk_out;
        logic data_out;
    } iox_chain_s;

endpackage : iox_pkg

// ### iox_sync.sv
// two flip-flop synchroniser for pin levels
// assumes the pins are asynchronous to clock
module iox_sync
    import iox_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clock, // system clock
    input wire logic rst_b, // sync reset, active low
    input wire logic ce, // clock enable
    input wire logic [W-1:0] d, // asynchronous levels
    output logic [W-1:0] q // synchronised levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } iox_sync_st_s;

    iox_sync_st_s st_reg;
    iox_sync_st_s st_next;

    always_comb begin
        st_next = st_reg;
        if (ce) begin
            st_next.s1 = d;
            st_next.s2 = st_reg.s1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.s2;
endmodule : iox_sync

// ### iox_alloc_slot.sv
// one allocation step: take the lowest free permitted port
// assumes used_in holds the ports taken by all higher-priority functions
module iox_alloc_slot
    import iox_pkg::*;
(
    input wire logic en, // function enabled
    input wire logic [IOX_NPORT-1:0] allowed, // permitted ports
    input wire logic [IOX_NPORT-1:0] used_in, // ports already taken
    output logic [IOX_NPORT-1:0] sel, // one-hot port taken, zero if none
    output logic [IOX_NPORT-1:0] used_out // ports taken after this step
);
    logic [IOX_NPORT-1:0] free;
    logic [IOX_NPORT-1:0] lowest;

    always_comb begin
        free = allowed & ~used_in;
        // two's complement trick isolates the lowest set bit; none free gives zero
        lowest = free & IOX_NPORT'(~free + 6'h01);
        sel = en ? lowest : IOX_NO_PORT;
        used_out = used_in | sel;
    end
endmodule : iox_alloc_slot

// ### iox_crossbar.sv
// io crossbar: maps enabled internal functions onto six general io ports
// assumes register writes come from the host serial slave on the same clock;
// io_in is asynchronous, all other inputs are on clock

// What this block does
// - each function takes lowest free permitted port
// - allocate in fixed descending function priority
// - sensor pins restricted to io1 to io4
// - other functions restricted to listed port ranges
// - pin-set codes one to three choose sensor pins
// - pin-set codes five to seven add select
// - clock source bit picks internal or io
// - interrupt routed to port only when enabled
// - chain clock output routed only when enabled
// - chain data input tied low unless routed
// - chain out and return looped unless routed
// - coupler pin follows open and close commands
// - chained slave data passes through unchanged
// - sensor data goes to own channel
// - interrupt pin carries link and latch events
// - sensor master uses pins only when enabled
module iox_crossbar
    import iox_pkg::*;
(
    input wire logic clock, // 50 MHz system clock
    input wire logic rst_b, // sync reset, active low
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic [IOX_AW-1:0] reg_addr, // register address
    input wire logic reg_wr, // register write strobe
    input wire logic [IOX_DW-1:0] reg_wdata, // register write data
    output logic [IOX_DW-1:0] reg_rdata, // register read data, one cycle after address
    input wire logic [IOX_NPORT-1:0] io_in, // port pin levels
    output logic [IOX_NPORT-1:0] io_out, // port drive levels
    output logic [IOX_NPORT-1:0] io_oe, // port drive enables, high drives
    input wire iox_sens_s sens, // sensor master outputs
    output logic sens_miso, // sensor data into sensor channel
    output logic sens_master_en, // sensor master enable
    output logic ext_clk_sel, // high selects external clock
    output logic ext_clk_level, // external clock level from port
    input wire logic irq_req, // link event request
    input wire logic latch_event, // position latch event pulse
    input wire iox_chain_s chain, // chain clock and data towards slaves
    output logic chain_data_in, // chain data from port or zero
    output logic chain_data_return, // chain return data
    input wire logic cpl_open_cmd, // link command opens bus structure
    input wire logic cpl_close_cmd, // link command closes bus structure
    output logic coupler_level // coupler control state
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [IOX_DW-1:0] xbar;
        logic [IOX_DW-1:0] cmd;
        logic [IOX_DW-1:0] sens_cfg;
        iox_cpl_e cpl;
        logic [IOX_NPORT-1:0] io_out;
        logic [IOX_NPORT-1:0] io_oe;
        logic [IOX_NPORT-1:0] out_claim;
        logic [IOX_DW-1:0] rdata;
        logic sens_miso;
        logic ext_clk_level;
        logic chain_in;
        logic chain_ret;
    } iox_st_s;

    iox_st_s st_reg;
    iox_st_s st_next;

    logic [IOX_NPORT-1:0] io_sync;
    logic [IOX_NFUNC-1:0] fn_en;
    logic [IOX_NFUNC-1:0] fn_val;
    logic [IOX_NFUNC-1:0] fn_in;
    logic [IOX_NPORT-1:0] sel [IOX_NFUNC];
    logic [IOX_NPORT-1:0] used [IOX_NFUNC+1];
    logic [2:0] pin_set;
    logic sens_en;

    iox_sync #(
        .W(IOX_NPORT)
    ) u_io_sync (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .d(io_in),
        .q(io_sync)
    );

    // ****************************************************************
    // function enables
    // ****************************************************************
    assign pin_set = st_reg.xbar[IOX_XB_PINSET_MSB:IOX_XB_PINSET_LSB];
    assign sens_en = st_reg.sens_cfg[IOX_SENS_EN_BIT];

    always_comb begin
        fn_en = '0;
        // reserved pin-set code claims nothing
        unique case (pin_set)
            IOX_PS_CK_DO_DI, IOX_PS_CK_DO_DI_CS: begin
                fn_en[FN_SCLK] = 1'b1;
                fn_en[FN_DOUT] = 1'b1;
                fn_en[FN_DIN] = 1'b1;
            end
            IOX_PS_CK_DO, IOX_PS_CK_DO_CS: begin
                fn_en[FN_SCLK] = 1'b1;
                fn_en[FN_DOUT] = 1'b1;
            end
            IOX_PS_CK_DI, IOX_PS_CK_DI_CS: begin
                fn_en[FN_SCLK] = 1'b1;
                fn_en[FN_DIN] = 1'b1;
            end
            IOX_PS_NONE, IOX_PS_RSVD: begin
                fn_en[FN_SCLK] = 1'b0;
            end
        endcase
        fn_en[FN_SEL] = pin_set[2] && (pin_set != IOX_PS_RSVD);
        fn_en[FN_CLK] = st_reg.xbar[IOX_XB_CLK_BIT];
        fn_en[FN_IRQ] = st_reg.xbar[IOX_XB_IRQ_BIT];
        fn_en[FN_MAO] = st_reg.xbar[IOX_XB_MAO_BIT];
        fn_en[FN_SLI] = st_reg.xbar[IOX_XB_SLI_BIT];
        fn_en[FN_CPL] = st_reg.cmd[IOX_CMD_CPL_BIT];
        fn_en[FN_CHAIN_DATA_OUT] = st_reg.xbar[IOX_XB_SLO_BIT];
        fn_en[FN_CHAIN_DATA_RETURN] = st_reg.xbar[IOX_XB_SLO_BIT];
    end

    // ****************************************************************
    // priority allocation chain
    // ****************************************************************
    assign used[0] = IOX_NO_PORT;

    for (genvar f = 0; f < IOX_NFUNC; f++) begin : g_slot
        // chain order is the priority order
        iox_alloc_slot u_slot (
            .en(fn_en[f]),
            .allowed(FN_ALLOWED[f]),
            .used_in(used[f]),
            .sel(sel[f]),
            .used_out(used[f+1])
        );
        assign fn_in[f] = |(sel[f] & io_sync);
    end

    // ****************************************************************
    // output function values
    // ****************************************************************
    always_comb begin
        fn_val = '0;
        fn_val[FN_SCLK] = sens.sclk;
        fn_val[FN_DOUT] = sens.mosi;
        fn_val[FN_SEL] = sens.sel;
        fn_val[FN_IRQ] = irq_req | latch_event;
        fn_val[FN_MAO] = chain.clk_out;
        fn_val[FN_CPL] = (st_reg.cpl == IOX_CPL_OPEN);
        fn_val[FN_CHAIN_DATA_OUT] = chain.data_out;
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [IOX_NPORT-1:0] drv;
        logic [IOX_NPORT-1:0] oe;
        logic [IOX_NFUNC-1:0] out_fn;
        drv = IOX_NO_PORT;
        oe = IOX_NO_PORT;
        out_fn = FN_IS_OUT;
        // sensor outputs stay off the pins while the master is disabled
        if (!sens_en) begin
            out_fn[FN_SCLK] = 1'b0;
            out_fn[FN_DOUT] = 1'b0;
            out_fn[FN_SEL] = 1'b0;
        end
        for (int f = 0; f < IOX_NFUNC; f++) begin
            if (out_fn[f]) begin
                oe = oe | sel[f];
                drv = drv | (fn_val[f] ? sel[f] : IOX_NO_PORT);
            end
        end

        st_next = st_reg;
        if (ce) begin
            st_next.io_out = drv;
            st_next.io_oe = oe;
            st_next.out_claim = oe;
            // sensor bits enter the own sensor channel only
            st_next.sens_miso = sens_en & fn_in[FN_DIN];
            st_next.ext_clk_level = fn_in[FN_CLK];
            st_next.chain_in = fn_in[FN_SLI];
            // return path is forwarded bit for bit, no re-framing
            st_next.chain_ret = st_reg.xbar[IOX_XB_SLO_BIT] ? fn_in[FN_CHAIN_DATA_RETURN] : chain.data_out;

            // open wins if both commands arrive together
            if (cpl_open_cmd) begin
                st_next.cpl = IOX_CPL_OPEN;
            end else if (cpl_close_cmd) begin
                st_next.cpl = IOX_CPL_CLOSED;
            end

            if (reg_wr) begin
                unique case (reg_addr)
                    IOX_OFS_XBAR: st_next.xbar = reg_wdata;
                    IOX_OFS_CMD_CFG: st_next.cmd = reg_wdata;
                    IOX_OFS_SENS_CFG: st_next.sens_cfg = reg_wdata;
                    default: st_next.xbar = st_reg.xbar;
                endcase
            end

            unique case (reg_addr)
                IOX_OFS_XBAR: st_next.rdata = st_reg.xbar;
                IOX_OFS_CMD_CFG: st_next.rdata = st_reg.cmd;
                IOX_OFS_SENS_CFG: st_next.rdata = st_reg.sens_cfg;
                IOX_OFS_MAP_STAT: st_next.rdata = IOX_DW'(used[IOX_NFUNC]);
                default: st_next.rdata = IOX_RD_NONE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st_reg.xbar <= IOX_RST_XBAR;
            st_reg.cmd <= IOX_RST_CMD_CFG;
            st_reg.sens_cfg <= IOX_RST_SENS_CFG;
            st_reg.cpl <= IOX_CPL_CLOSED;
            st_reg.io_out <= IOX_NO_PORT;
            st_reg.io_oe <= IOX_NO_PORT;
            st_reg.out_claim <= IOX_NO_PORT;
            st_reg.rdata <= IOX_RD_NONE;
            st_reg.sens_miso <= 1'b0;
            st_reg.ext_clk_level <= 1'b0;
            st_reg.chain_in <= 1'b0;
            st_reg.chain_ret <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata = st_reg.rdata;
    assign io_out = st_reg.io_out;
    assign io_oe = st_reg.io_oe;
    assign sens_miso = st_reg.sens_miso;
    assign sens_master_en = sens_en;
    assign ext_clk_sel = st_reg.xbar[IOX_XB_CLK_BIT];
    assign ext_clk_level = st_reg.ext_clk_level;
    assign chain_data_in = st_reg.chain_in;
    assign chain_data_return = st_reg.chain_ret;
    assign coupler_level = (st_reg.cpl == IOX_CPL_OPEN);

    // ****************************************************************
    // checks
    // ****************************************************************
    logic bad_lowest;
    logic bad_allowed;

    always_comb begin
        bad_lowest = 1'b0;
        bad_allowed = 1'b0;
        for (int f = 0; f < IOX_NFUNC; f++) begin
            if (sel[f] != IOX_NO_PORT) begin
                if ((FN_ALLOWED[f] & ~used[f] & IOX_NPORT'(sel[f] - 6'h01)) != IOX_NO_PORT) begin
                    bad_lowest = 1'b1;
                end
            end
            if ((sel[f] & ~FN_ALLOWED[f]) != IOX_NO_PORT) begin
                bad_allowed = 1'b1;
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    AST_LOWEST_FREE: assert property (!bad_lowest)
        else $error("function skipped a lower free port");

    AST_PRIORITY: assert property (
        (pin_set == IOX_PS_NONE && fn_en[FN_CLK]) |-> sel[FN_CLK] == IOX_PORT1)
        else $error("clock input not on io1 with sensor pins off");

    AST_SCLK_IO1: assert property (
        fn_en[FN_SCLK] |-> sel[FN_SCLK] == IOX_PORT1)
        else $error("sensor clock not on io1");

    AST_ALLOWED: assert property (!bad_allowed)
        else $error("function on a forbidden port");

    AST_RSVD_CODE: assert property (
        pin_set == IOX_PS_RSVD |-> fn_en[FN_SEL:FN_SCLK] == 4'h0)
        else $error("reserved pin-set code claimed sensor pins");

    AST_SELECT_ADDED: assert property (
        (pin_set > IOX_PS_RSVD) |-> (fn_en[FN_SEL] && sel[FN_SEL] != IOX_NO_PORT))
        else $error("select not placed for select pin-set");

    AST_CLK_INTERNAL: assert property (
        (ce && !st_reg.xbar[IOX_XB_CLK_BIT]) |=> !ext_clk_level)
        else $error("external clock level seen while internal selected");

    AST_IRQ_UNUSED: assert property (
        !st_reg.xbar[IOX_XB_IRQ_BIT] |-> sel[FN_IRQ] == IOX_NO_PORT)
        else $error("interrupt claimed a port while unrouted");

    AST_SLI_TIE: assert property (
        (ce && !st_reg.xbar[IOX_XB_SLI_BIT]) |=> !chain_data_in)
        else $error("chain data input not tied low");

    AST_SLO_LOOP: assert property (
        (ce && !st_reg.xbar[IOX_XB_SLO_BIT]) |=> chain_data_return == $past(chain.data_out))
        else $error("chain return not looped to chain out");

    AST_CPL_FOLLOW: assert property (
        (ce && cpl_close_cmd && !cpl_open_cmd) |=> !coupler_level ##1 (!coupler_level || $past(cpl_open_cmd)))
        else $error("coupler control ignored close command");

    AST_UNCLAIMED_Z: assert property (
        ce |=> (io_oe & ~$past(used[IOX_NFUNC])) == IOX_NO_PORT)
        else $error("unclaimed port is driven");

    AST_SENS_OFF: assert property (
        (ce && !sens_en) |=> (io_oe & $past(sel[FN_SCLK] | sel[FN_DOUT] | sel[FN_SEL])) == IOX_NO_PORT)
        else $error("sensor pin driven while master disabled");

    AST_MAO_UNUSED: assert property (
        !st_reg.xbar[IOX_XB_MAO_BIT] |-> sel[FN_MAO] == IOX_NO_PORT)
        else $error("chain clock claimed a port while unrouted");

    AST_CPL_UNUSED: assert property (
        !st_reg.cmd[IOX_CMD_CPL_BIT] |-> sel[FN_CPL] == IOX_NO_PORT)
        else $error("coupler pin claimed a port while unrouted");

    AST_MISO_OFF: assert property (
        (ce && !sens_en) |=> !sens_miso)
        else $error("sensor data passed while master disabled");

    // irq is always an output, so its port must show the request one cycle on
    AST_IRQ_LEVEL: assert property (
        (ce && sel[FN_IRQ] != IOX_NO_PORT)
        |=> ((io_out & $past(sel[FN_IRQ])) != IOX_NO_PORT) == $past(irq_req || latch_event))
        else $error("interrupt port does not follow the request");

endmodule : iox_crossbar

// ### iox_far_end.sv
// far side of the six io ports: sensor, coupler and chained slaves
// assumes the bench sets the levels that the far parties drive
module iox_far_end (
    input wire logic [5:0] io_out, // port drive levels
    input wire logic [5:0] io_oe, // port drive enables
    input wire logic [5:0] far_lvl, // levels driven from outside
    output logic [5:0] io_in // resolved wire levels
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // wire resolution
    // ****************************************************************
    // far parties only drive ports that the device leaves as inputs
    assign io_in = (io_out & io_oe) | (far_lvl & ~io_oe);
endmodule : iox_far_end

// ### io_crossbar_priority_mapper_test.sv
// self-checking bench of the io crossbar
// assumes one 50 MHz clock and the far-side model on the six ports
module io_crossbar_priority_mapper_test
    import iox_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // signals
    // ****************************************************************
    localparam logic [5:0] ALLOW [11] = '{6'h01, 6'h02, 6'h06, 6'h0c, 6'h3f, 6'h3f, 6'h3e, 6'h3c, 6'h38, 6'h30, 6'h20};
    localparam logic [10:0] OUTS = 11'h36b;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic reg_wr = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [5:0] io_in, io_out, io_oe, claim, oe;
    logic [5:0] far_lvl = 6'h00;
    iox_sens_s sens = '0;
    iox_chain_s chain = '0;
    logic irq_req = 1'b0;
    logic latch_event = 1'b0;
    logic cpl_open_cmd = 1'b0;
    logic cpl_close_cmd = 1'b0;
    logic sens_miso, sens_master_en, ext_clk_sel, ext_clk_level;
    logic chain_data_in, chain_data_return, coupler_level;
    logic cpl_st = 1'b0;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int pt [11];

    iox_crossbar dut (.clock(clock), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .sens(sens), .sens_miso(sens_miso), .sens_master_en(sens_master_en), .ext_clk_sel(ext_clk_sel),
        .ext_clk_level(ext_clk_level), .irq_req(irq_req), .latch_event(latch_event), .chain(chain),
        .chain_data_in(chain_data_in), .chain_data_return(chain_data_return), .cpl_open_cmd(cpl_open_cmd),
        .cpl_close_cmd(cpl_close_cmd), .coupler_level(coupler_level));
    iox_far_end far (.io_out(io_out), .io_oe(io_oe), .far_lvl(far_lvl), .io_in(io_in));

    always #10 clock = ~clock;

    // ****************************************************************
    // tasks
    // ****************************************************************
    task results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    // hang guard, generous against about 1400 cycles of tests
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            bad_count++;
            results();
        end
    end

    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // strobe dropped a full cycle before any next write
    task wr(input logic [6:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        @(negedge clock);
    endtask : wr

    task rd(input logic [6:0] a, input logic [7:0] exp);
        reg_addr = a;
        repeat (2) @(negedge clock);
        check("reg_rdata", reg_rdata, exp);
    endtask : rd

    task cmd(input logic o, input logic c, input logic exp);
        cpl_open_cmd = o;
        cpl_close_cmd = c;
        @(negedge clock);
        cpl_open_cmd = 1'b0;
        cpl_close_cmd = 1'b0;
        @(negedge clock);
        cpl_st = exp;
        check("coupler_level", 8'(coupler_level), 8'(exp));
    endtask : cmd

    // reference allocation, one function at a time in priority order
    task calc(input logic [7:0] xb, input logic c5, input logic se);
        logic [10:0] en;
        logic [2:0] ps;
        ps = xb[2:0];
        en[0] = ps != 3'h0 && ps != 3'h4;
        en[1] = ps inside {3'h1, 3'h2, 3'h5, 3'h6};
        en[2] = ps inside {3'h1, 3'h3, 3'h5, 3'h7};
        en[3] = ps[2] && ps != 3'h4;
        en[10:4] = {xb[7], xb[7], c5, xb[6:3]};
        claim = '0;
        oe = '0;
        for (int f = 0; f < 11; f++) begin
            pt[f] = -1;
            for (int p = 0; p < 6; p++) begin
                if (en[f] && ALLOW[f][p] && !claim[p] && pt[f] < 0) begin
                    pt[f] = p;
                    claim[p] = 1'b1;
                    oe[p] = OUTS[f] && (f > 3 || se);
                end
            end
        end
    endtask : calc

    function automatic logic lv(int f);
        return pt[f] < 0 ? 1'b0 : far_lvl[pt[f]];
    endfunction : lv

    task run(input logic [7:0] xb, input logic c5, input logic se);
        logic [5:0] ex;
        logic [10:0] fv;
        wr(IOX_OFS_XBAR, xb);
        wr(IOX_OFS_CMD_CFG, {2'h0, c5, 5'h00});
        wr(IOX_OFS_SENS_CFG, {1'b0, se, 6'h00});
        far_lvl = 6'($urandom);
        sens = 3'($urandom);
        chain = 2'($urandom);
        irq_req = 1'($urandom);
        latch_event = 1'($urandom);
        calc(xb, c5, se);
        fv = {1'b0, chain.data_out, cpl_st, 1'b0, chain.clk_out, irq_req | latch_event, 1'b0, sens.sel, 1'b0,
            sens.mosi, sens.sclk};
        ex = '0;
        for (int f = 0; f < 11; f++) begin
            if (pt[f] >= 0) begin
                ex[pt[f]] = fv[f];
            end
        end
        repeat (6) @(negedge clock);
        check("io_oe", 8'(io_oe), 8'(oe));
        check("io_out", 8'(io_out & oe), 8'(ex & oe));
        check("sens_master_en", 8'(sens_master_en), 8'(se));
        check("ext_clk_sel", 8'(ext_clk_sel), 8'(xb[3]));
        check("ext_clk_level", 8'(ext_clk_level), 8'(lv(4)));
        check("sens_miso", 8'(sens_miso), 8'(se & lv(2)));
        check("chain_data_in", 8'(chain_data_in), 8'(lv(7)));
        if (!xb[7]) begin
            check("chain_data_return", 8'(chain_data_return), 8'(chain.data_out));
        end else begin
            check("chain_data_return", 8'(chain_data_return), 8'(lv(10)));
        end
        rd(IOX_OFS_MAP_STAT, 8'(claim));
    endtask : run

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'h1d00));
        repeat (4) @(negedge clock);
        rst_b = 1'b1;
        @(negedge clock);
        rd(IOX_OFS_XBAR, IOX_RST_XBAR);
        rd(IOX_OFS_CMD_CFG, IOX_RST_CMD_CFG);
        rd(7'h7f, IOX_RD_NONE);
        wr(IOX_OFS_MAP_STAT, 8'hff);
        rd(IOX_OFS_MAP_STAT, 8'h00);
        wr(IOX_OFS_XBAR, 8'ha5);
        rd(IOX_OFS_XBAR, 8'ha5);
        cmd(1'b1, 1'b0, 1'b1);
        cmd(1'b0, 1'b1, 1'b0);
        cmd(1'b1, 1'b1, 1'b1);
        // clock enable low must freeze the coupler state against a close
        ce = 1'b0;
        cmd(1'b0, 1'b1, 1'b1);
        ce = 1'b1;
        // every pin-set code, once crowded by all other functions, once alone
        for (int i = 0; i < 8; i++) begin
            run({5'h1f, 3'(i)}, 1'b1, 1'b1);
            run({5'h00, 3'(i)}, 1'b0, 1'b1);
        end
        run(8'hf5, 1'b0, 1'b0);
        for (int i = 0; i < 80; i++) begin
            run(8'($urandom), 1'($urandom), 1'($urandom));
        end
        // mid-run reset drops every claim and closes the coupler
        rst_b = 1'b0;
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        check("coupler_level", 8'(coupler_level), 8'h00);
        check("io_oe", 8'(io_oe), 8'h00);
        rd(IOX_OFS_XBAR, IOX_RST_XBAR);
        results();
    end
endmodule : io_crossbar_priority_mapper_test
